// ==== hdl/hme_pkg.sv ====
// package of opcodes, field positions and carrier types for the move/multiply unit
package hme_pkg;

  // ****************************************************************
  // instruction encoding
  // ****************************************************************
  localparam logic [5:0] HME_OP_SPECIAL   = 6'h00;
  localparam logic [5:0] HME_OP_SYSCTL    = 6'h10; // sysctl_major_opcode
  localparam logic [4:0] HME_SC_READ      = 5'h00;
  localparam logic [4:0] HME_SC_WRITE     = 5'h04;
  localparam logic [5:0] HME_FN_COPY_UP   = 6'h10;
  localparam logic [5:0] HME_FN_SET_UP    = 6'h11;
  localparam logic [5:0] HME_FN_COPY_BOT  = 6'h12;
  localparam logic [5:0] HME_FN_SET_BOT   = 6'h13;
  localparam logic [5:0] HME_FN_SMUL      = 6'h18;
  localparam logic [5:0] HME_FN_UMUL      = 6'h19;
  localparam logic [5:0] HME_FN_OR        = 6'h25;
  localparam logic [5:0] HME_FN_NOR       = 6'h27;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int HME_OP_HI   = 31;
  localparam int HME_OP_LO   = 26;
  localparam int HME_SA_HI   = 25;
  localparam int HME_SA_LO   = 21;
  localparam int HME_SB_HI   = 20;
  localparam int HME_SB_LO   = 16;
  localparam int HME_DS_HI   = 15;
  localparam int HME_DS_LO   = 11;
  localparam int HME_SH_HI   = 10;
  localparam int HME_SH_LO   = 6;
  localparam int HME_FN_HI   = 5;
  localparam int HME_FN_LO   = 0;
  localparam int HME_WORD    = 32;
  localparam int HME_DWORD   = 64;

  // issued instructions a multiply must trail a product copy by before it is not flagged undefined
  localparam logic [1:0] HME_UNDEF_WIN = 2'h2;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef enum logic [2:0] {
    HME_PM_USER  = 3'h1,
    HME_PM_SUPER = 3'h2,
    HME_PM_KERN  = 3'h4
  } hme_mode_e;

  // one issued instruction with its operands
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic [63:0] src_a;
    logic [63:0] src_b;
  } hme_issue_s;

  // general-register write back
  typedef struct packed {
    logic        en;
    logic [4:0]  idx;
    logic [63:0] data;
  } hme_gpr_wr_s;

  // system_control_unit register access
  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [4:0]  idx;
    logic [63:0] data;
  } hme_sc_acc_s;

  // state of the product multiplier
  typedef struct packed {
    logic [63:0] prod;
  } hme_mul_st_s;

  // state of the pair of product registers
  typedef struct packed {
    logic [63:0] upper;
    logic [63:0] bottom;
    logic        mul_pend;   // multiply seen, no product move since
  } hme_prod_st_s;

endpackage

// ==== hdl/hme_mul32.sv ====
// 32x32 signed or unsigned multiplier with a registered product
`timescale 1ns/1ns
module hme_mul32
  import hme_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        is_signed,
  input  wire logic [31:0] op_a,
  input  wire logic [31:0] op_b,
  output logic      [63:0] prod
);

  // ****************************************************************
  // state
  // ****************************************************************
  hme_mul_st_s st_q;
  hme_mul_st_s st_d;

  // extend to 33 bits so one signed multiplier covers both flavours
  always_comb begin
    logic signed [32:0] ea;
    logic signed [32:0] eb;
    logic signed [65:0] full;
    ea   = '0;
    eb   = '0;
    full = '0;
    st_d = st_q;
    ea   = {is_signed & op_a[HME_WORD-1], op_a};
    eb   = {is_signed & op_b[HME_WORD-1], op_b};
    full = ea * eb; // no overflow check exists by design
    st_d.prod = full[HME_DWORD-1:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prod = st_q.prod;

endmodule

// ==== hdl/hme_prod_regs.sv ====
// the product_upper_reg / product_bottom_reg pair with its write ports
`timescale 1ns/1ns
module hme_prod_regs
  import hme_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        mul_done,
  input  wire logic [63:0] mul_prod,
  input  wire logic        wide_mode,
  input  wire logic        set_up,
  input  wire logic        set_bot,
  input  wire logic        any_move,
  input  wire logic [63:0] gpr_val,
  output logic      [63:0] upper,
  output logic      [63:0] bottom,
  output logic             mul_pend
);

  // ****************************************************************
  // state
  // ****************************************************************
  hme_prod_st_s st_q;
  hme_prod_st_s st_d;

  function automatic logic [63:0] sx_half(input logic [31:0] h);
    sx_half = {{HME_WORD{h[HME_WORD-1]}}, h};
  endfunction

  // product wins over direct sets; the sets after a multiply are undefined
  always_comb begin
    st_d = st_q;
    if (set_up) begin
      st_d.upper = gpr_val;
    end
    if (set_bot) begin
      st_d.bottom = gpr_val;
    end
    if (any_move) begin
      st_d.mul_pend = 1'b0;
    end
    if (mul_done) begin
      // low word to bottom, high word to upper
      if (wide_mode) begin
        st_d.bottom = sx_half(mul_prod[31:0]);
        st_d.upper  = sx_half(mul_prod[63:32]);
      end else begin
        st_d.bottom = {32'h0, mul_prod[31:0]};
        st_d.upper  = {32'h0, mul_prod[63:32]};
      end
      st_d.mul_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign upper    = st_q.upper;
  assign bottom   = st_q.bottom;
  assign mul_pend = st_q.mul_pend;

endmodule

// ==== hdl/hme_move_exec.sv ====
// decode and execute: sysctl moves, product moves, multiplies, OR and NOR
//
// Summary of operation
// - decode sysctl read into source_b register
// - sysctl moves trap outside kernel mode when unit disabled
// - sysctl write: read gpr, write next cycle
// - copy product_upper_reg into dest register
// - copy product_bottom_reg into dest register
// - set product_upper_reg from source_a register
// - upper set after multiply is undefined
// - set product_bottom_reg; undefined after multiply
// - signed 32-bit multiply, never overflow trap
// - unsigned multiply, never overflow trap
// - low word bottom, high word upper
// - NOR of sources into dest register
// - OR of sources into dest register
`timescale 1ns/1ns
module hme_move_exec
  import hme_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  hme_issue_s       issue,
  input  hme_mode_e        priv_mode,
  input  wire logic        sysctl_usable,
  input  wire logic        wide_mode,
  input  wire logic [63:0] sc_rd_data,
  output hme_gpr_wr_s      gpr_wr,
  output hme_sc_acc_s      sc_acc,
  output logic             exc_cop_unusable,
  output logic             exc_reserved,
  output logic             mul_busy,
  output logic             prod_undef
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    hme_gpr_wr_s gpr;
    hme_sc_acc_s sc;
    logic        sc_rd_pend;   // sysctl read data due back next cycle
    logic [4:0]  sc_rd_dst;
    logic        mul_run;      // product lands one cycle after issue
    logic        mul_sgn;
    logic        cop_unu;
    logic        resv;
    logic [1:0]  since_copy;   // instructions since last product copy
    logic        undef;
  } hme_exec_st_s;

  // registered copy of all state; st_d is its next value
  hme_exec_st_s st_q;
  hme_exec_st_s st_d;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic is_special(input logic [31:0] w);
    is_special = w[HME_OP_HI:HME_OP_LO] == HME_OP_SPECIAL;
  endfunction

  function automatic logic fn_is(input logic [31:0] w,
                                 input logic [5:0]  f);
    fn_is = is_special(w) && w[HME_FN_HI:HME_FN_LO] == f;
  endfunction

  // sysctl major opcode with the given sub-op; both moves need the
  // whole low tail clear
  function automatic logic sc_is(input logic [31:0] w,
                                 input logic [4:0]  sub);
    sc_is = w[HME_OP_HI:HME_OP_LO] == HME_OP_SYSCTL &&
            w[HME_SA_HI:HME_SA_LO] == sub &&
            w[HME_SH_HI:0] == '0;
  endfunction

  // product copies carry only a destination; both sources are zero
  function automatic logic zf_copy(input logic [31:0] w);
    zf_copy = w[HME_SA_HI:HME_SB_LO] == '0 &&
              w[HME_SH_HI:HME_SH_LO] == '0;
  endfunction

  // product sets carry only source_a
  function automatic logic zf_set(input logic [31:0] w);
    zf_set = w[HME_SB_HI:HME_SH_LO] == '0;
  endfunction

  // multiplies have no destination and no shift amount
  function automatic logic zf_mul(input logic [31:0] w);
    zf_mul = w[HME_DS_HI:HME_SH_LO] == '0;
  endfunction

  // register logic ops must leave the shift amount clear
  function automatic logic zf_logic(input logic [31:0] w);
    zf_logic = w[HME_SH_HI:HME_SH_LO] == '0;
  endfunction

  // ****************************************************************
  // field extraction
  // ****************************************************************
  // destination field, shared by every op that writes a general register except the sysctl read
  function automatic logic [4:0] fld_dst(input logic [31:0] w);
    fld_dst = w[HME_DS_HI:HME_DS_LO];
  endfunction

  // source_b field, where a sysctl read lands; the same bits hold
  // the value to store on a sysctl write
  function automatic logic [4:0] fld_srcb(input logic [31:0] w);
    fld_srcb = w[HME_SB_HI:HME_SB_LO];
  endfunction

  // one decoded strobe per instruction, all qualified by valid
  logic [31:0] w;
  logic        dec_sc_rd;
  logic        dec_sc_wr;
  logic        dec_cp_up;
  logic        dec_cp_bot;
  logic        dec_set_up;
  logic        dec_set_bot;
  logic        dec_smul;
  logic        dec_umul;
  logic        dec_or;
  logic        dec_nor;
  logic        sc_denied;

  assign w = issue.word;

  // field checks follow each encoding's zero fields; a valid word
  // that fails them falls through to the reserved flag
  always_comb begin
    // sysctl moves
    dec_sc_rd   = issue.valid && sc_is(w, HME_SC_READ);
    dec_sc_wr   = issue.valid && sc_is(w, HME_SC_WRITE);
    // product moves
    dec_cp_up   = issue.valid && fn_is(w, HME_FN_COPY_UP) &&
                  zf_copy(w);
    dec_cp_bot  = issue.valid && fn_is(w, HME_FN_COPY_BOT) &&
                  zf_copy(w);
    dec_set_up  = issue.valid && fn_is(w, HME_FN_SET_UP) &&
                  zf_set(w);
    dec_set_bot = issue.valid && fn_is(w, HME_FN_SET_BOT) &&
                  zf_set(w);
    // multiplies
    dec_smul    = issue.valid && fn_is(w, HME_FN_SMUL) &&
                  zf_mul(w);
    dec_umul    = issue.valid && fn_is(w, HME_FN_UMUL) &&
                  zf_mul(w);
    // register logic
    dec_or      = issue.valid && fn_is(w, HME_FN_OR) &&
                  zf_logic(w);
    dec_nor     = issue.valid && fn_is(w, HME_FN_NOR) &&
                  zf_logic(w);
    // kernel mode always has the unit; others need the enable
    sc_denied   = priv_mode != HME_PM_KERN && !sysctl_usable;
  end

  // ****************************************************************
  // product path
  // ****************************************************************
  // assembled product and the product registers as seen here
  logic [63:0] mul_prod;
  logic [63:0] p_upper;
  logic [63:0] p_bottom;
  logic        p_mul_pend;
  logic        any_move;

  // a product move closes the undefined window after a multiply, except one issued in the cycle right after it
  assign any_move = dec_cp_up | dec_cp_bot | dec_set_up | dec_set_bot;

  // operands taken at issue; the product is registered inside
  hme_mul32 u_mul (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .is_signed (dec_smul),
    .op_a      (issue.src_a[31:0]),
    .op_b      (issue.src_b[31:0]),
    .prod      (mul_prod)
  );

  // sets land at issue, products one cycle after the multiply
  hme_prod_regs u_prod (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .mul_done  (st_q.mul_run),
    .mul_prod  (mul_prod),
    .wide_mode (wide_mode),
    .set_up    (dec_set_up),
    .set_bot   (dec_set_bot),
    .any_move  (any_move),
    .gpr_val   (issue.src_a),
    .upper     (p_upper),
    .bottom    (p_bottom),
    .mul_pend  (p_mul_pend)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  // one instruction per issue; each result is registered once and
  // the pulse-type fields are cleared every cycle
  always_comb begin
    st_d          = st_q;
    st_d.gpr      = '0;
    st_d.sc       = '0;
    st_d.cop_unu  = 1'b0;
    st_d.resv     = 1'b0;
    st_d.mul_run  = dec_smul | dec_umul;
    st_d.mul_sgn  = dec_smul;
    st_d.undef    = 1'b0;
    st_d.sc_rd_pend = 1'b0;

    // sysctl read result returns a cycle after the request
    // it shares the write port: a register-writing op issued right
    // behind the read takes this slot instead
    if (st_q.sc_rd_pend) begin
      st_d.gpr.en   = 1'b1;
      st_d.gpr.idx  = st_q.sc_rd_dst;
      st_d.gpr.data = sc_rd_data;
    end

    // count issued words since the last copy, saturating at the
    // window so that a long stretch cannot wrap back into it
    if (issue.valid) begin
      st_d.since_copy = (st_q.since_copy == HME_UNDEF_WIN) ?
                        st_q.since_copy : st_q.since_copy + 2'h1;
    end

    // a refused sysctl op leaves no access and no write behind
    if ((dec_sc_rd | dec_sc_wr) && sc_denied) begin
      st_d.cop_unu = 1'b1;
    end else if (dec_sc_rd) begin
      // request now; the unit answers in the following cycle
      st_d.sc.rd_en   = 1'b1;
      st_d.sc.idx     = fld_dst(w);
      st_d.sc_rd_pend = 1'b1;
      st_d.sc_rd_dst  = fld_srcb(w);
    end else if (dec_sc_wr) begin
      // value read at issue, written into the unit one cycle later
      st_d.sc.wr_en = 1'b1;
      st_d.sc.idx   = fld_dst(w);
      st_d.sc.data  = issue.src_b;
    end else if (dec_cp_up) begin
      // a copy restarts the spacing count for later multiplies
      st_d.gpr.en   = 1'b1;
      st_d.gpr.idx  = fld_dst(w);
      st_d.gpr.data = p_upper;
      st_d.since_copy = '0;
    end else if (dec_cp_bot) begin
      st_d.gpr.en   = 1'b1;
      st_d.gpr.idx  = fld_dst(w);
      st_d.gpr.data = p_bottom;
      st_d.since_copy = '0;
    end else if (dec_or) begin
      // logic results take all 64 bits in either mode
      st_d.gpr.en   = 1'b1;
      st_d.gpr.idx  = fld_dst(w);
      st_d.gpr.data = issue.src_a | issue.src_b;
    end else if (dec_nor) begin
      st_d.gpr.en   = 1'b1;
      st_d.gpr.idx  = fld_dst(w);
      st_d.gpr.data = ~(issue.src_a | issue.src_b);
    end else if (issue.valid && !(dec_smul | dec_umul | dec_set_up |
                                  dec_set_bot)) begin
      // multiplies and sets work through the product path instead
      st_d.resv = 1'b1; // not ours or malformed zero field
    end

    // set issued once a multiply's product has landed, with no move between: flag as undefined
    // the value is still written; only the flag marks it
    if ((dec_set_up | dec_set_bot) && p_mul_pend) begin
      st_d.undef = 1'b1;
    end
    // a multiply too soon after a copy is software's fault; flag it
    if ((dec_smul | dec_umul) && st_q.since_copy < HME_UNDEF_WIN) begin
      st_d.undef = 1'b1;
    end
  end

  // since_copy starts saturated: no copy precedes reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q            <= '0;
      st_q.since_copy <= HME_UNDEF_WIN;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs straight from flip-flops
  // ****************************************************************
  // every result is a one-cycle pulse; nothing is held
  assign gpr_wr           = st_q.gpr;
  assign sc_acc           = st_q.sc;
  assign exc_cop_unusable = st_q.cop_unu;
  assign exc_reserved     = st_q.resv;
  assign mul_busy         = st_q.mul_run;
  assign prod_undef       = st_q.undef;

endmodule

// ==== bench/hme_move_exec_properties.sv ====
// concurrent checks on the ports of the move/multiply execute unit
`timescale 1ns/1ns
module hme_exec_chk
  import hme_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire hme_issue_s  issue,
  input wire hme_mode_e   priv_mode,
  input wire logic        sysctl_usable,
  input wire logic        wide_mode,
  input wire logic [63:0] sc_rd_data,
  input wire hme_gpr_wr_s gpr_wr,
  input wire hme_sc_acc_s sc_acc,
  input wire logic        exc_cop_unusable,
  input wire logic        exc_reserved,
  input wire logic        mul_busy,
  input wire logic        prod_undef
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // own decode of the issued word, kept apart from the design's
  // ****************************************************************
  wire logic [5:0] fn     = issue.word[5:0];
  wire logic       spec   = issue.valid && issue.word[31:26] == HME_OP_SPECIAL;
  wire logic       sysc   = issue.valid && issue.word[31:26] == HME_OP_SYSCTL
                            && issue.word[10:0] == 11'h0;
  wire logic       is_scw = sysc && issue.word[25:21] == HME_SC_WRITE;
  wire logic       is_scr = sysc && issue.word[25:21] == HME_SC_READ;
  wire logic       sc_ok  = priv_mode == HME_PM_KERN || sysctl_usable;
  wire logic       is_log = spec && (fn == HME_FN_OR || fn == HME_FN_NOR);
  wire logic       is_mul = spec && issue.word[15:6] == 10'h0
                            && (fn == HME_FN_SMUL || fn == HME_FN_UMUL);

  // ****************************************************************
  // assertions
  // ****************************************************************
  chk_or_result: assert property (
    is_log && fn == HME_FN_OR && issue.word[10:6] == 5'h0 |=> gpr_wr.en
    && gpr_wr.idx == $past(issue.word[15:11])
    && gpr_wr.data == ($past(issue.src_a) | $past(issue.src_b)))
    else $error("or result wrong");
  chk_nor_result: assert property (
    is_log && fn == HME_FN_NOR && issue.word[10:6] == 5'h0 |=> gpr_wr.en
    && gpr_wr.idx == $past(issue.word[15:11])
    && gpr_wr.data == ~($past(issue.src_a) | $past(issue.src_b)))
    else $error("nor result wrong");
  chk_bad_shift: assert property (
    is_log && issue.word[10:6] != 5'h0 |=> exc_reserved && !gpr_wr.en)
    else $error("nonzero shift field accepted");
  chk_sc_write: assert property (
    is_scw && sc_ok |=> sc_acc.wr_en && !sc_acc.rd_en
    && sc_acc.idx == $past(issue.word[15:11])
    && sc_acc.data == $past(issue.src_b))
    else $error("sysctl write access wrong");
  chk_sc_read: assert property (
    is_scr && sc_ok |=> sc_acc.rd_en && sc_acc.idx == $past(issue.word[15:11])
    ##1 gpr_wr.en && gpr_wr.idx == $past(issue.word[20:16], 2))
    else $error("sysctl read access wrong");
  chk_read_data: assert property (
    sc_acc.rd_en |=> gpr_wr.data == $past(sc_rd_data))
    else $error("sysctl read data not returned");
  chk_cop_trap: assert property (
    (is_scw || is_scr) && !sc_ok |=> exc_cop_unusable
    && !sc_acc.rd_en && !sc_acc.wr_en)
    else $error("disabled sysctl access not trapped");
  chk_mul_busy: assert property (
    is_mul |=> mul_busy && !exc_reserved && !exc_cop_unusable)
    else $error("multiply did not start or trapped");
endmodule

bind hme_move_exec hme_exec_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .issue(issue), .priv_mode(priv_mode),
  .sysctl_usable(sysctl_usable), .wide_mode(wide_mode),
  .sc_rd_data(sc_rd_data), .gpr_wr(gpr_wr), .sc_acc(sc_acc),
  .exc_cop_unusable(exc_cop_unusable), .exc_reserved(exc_reserved),
  .mul_busy(mul_busy), .prod_undef(prod_undef));

// ==== bench/hme_testbench.sv ====
// self-checking bench for the move/multiply execute unit
`timescale 1ns/1ns
module testbench;
  import hme_pkg::*;
  logic        clk_sys;
  logic        rst_n;
  hme_issue_s  issue;
  hme_mode_e   priv_mode;
  logic        sysctl_usable;
  logic        wide_mode;
  logic [63:0] sc_rd_data;
  hme_gpr_wr_s gpr_wr;
  hme_sc_acc_s sc_acc;
  logic        exc_cop_unusable;
  logic        exc_reserved;
  logic        mul_busy;
  logic        prod_undef;
  int          n_mismatch;
  int          compares;
  localparam logic [31:0] SC_WR =
    {HME_OP_SYSCTL, HME_SC_WRITE, 10'h10c, 11'h0};
  localparam logic [31:0] SC_RD =
    {HME_OP_SYSCTL, HME_SC_READ, 10'h16c, 11'h0};

  hme_move_exec uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .issue(issue), .priv_mode(priv_mode),
    .sysctl_usable(sysctl_usable), .wide_mode(wide_mode),
    .sc_rd_data(sc_rd_data), .gpr_wr(gpr_wr), .sc_acc(sc_acc),
    .exc_cop_unusable(exc_cop_unusable), .exc_reserved(exc_reserved),
    .mul_busy(mul_busy), .prod_undef(prod_undef));

  // free-running 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic report(input logic [71:0] got, input logic [71:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_gpr(input logic [4:0] idx, input logic [63:0] d);
    report(72'(gpr_wr), {2'h0, 1'b1, idx, d});
  endtask
  // access data is only meaningful on a write, so it is masked otherwise
  task automatic chk_sc(input logic rd, input logic wr, input logic [63:0] d);
    report({1'b0, sc_acc.rd_en, sc_acc.wr_en, sc_acc.idx,
      sc_acc.wr_en ? sc_acc.data : 64'h0},
      {1'b0, rd, wr, (rd | wr) ? 5'h0c : 5'h00, d});
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    report(72'(got), 72'(exp));
  endtask
  function automatic logic [31:0] rw(logic [4:0] a, logic [4:0] d,
                                     logic [4:0] s, logic [5:0] f);
    return {HME_OP_SPECIAL, a, 5'h0, d, s, f};
  endfunction
  // issue one word; returns 1 ns after the clock edge that takes it
  task automatic op(input logic [31:0] w, input logic [63:0] a, b);
    issue = '{1'b1, w, a, b};
    @(posedge clk_sys);
    #1;
  endtask
  task automatic idle();
    issue.valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_set_copy();
    op(rw(5'h3, 5'h0, 5'h0, HME_FN_SET_UP), 64'h1234_5678_9abc_def0, 64'h0);
    chk_flag(prod_undef, 1'b0);
    op(rw(5'h4, 5'h0, 5'h0, HME_FN_SET_BOT), 64'h0fed_cba9_8765_4321, 64'h0);
    op(rw(5'h0, 5'h7, 5'h0, HME_FN_COPY_UP), 64'h0, 64'h0);
    chk_gpr(5'h7, 64'h1234_5678_9abc_def0);
    op(rw(5'h0, 5'h8, 5'h0, HME_FN_COPY_BOT), 64'h0, 64'h0);
    chk_gpr(5'h8, 64'h0fed_cba9_8765_4321);
    idle();
  endtask
  // three logic ops also serve as spacing after product copies
  task automatic t_logic(input logic [63:0] a, input logic [63:0] b);
    op(rw(5'h1, 5'h9, 5'h10, HME_FN_OR), a, b);
    chk_flag(exc_reserved, 1'b1);
    op(rw(5'h1, 5'h9, 5'h0, HME_FN_OR), a, b);
    chk_gpr(5'h9, a | b);
    op(rw(5'h1, 5'h1f, 5'h0, HME_FN_NOR), a, b);
    chk_gpr(5'h1f, ~(a | b));
    idle();
  endtask
  task automatic t_signed_product_op(input logic sgn, input logic wide,
                        input logic [31:0] a, input logic [31:0] b);
    logic [63:0] sa;
    logic [63:0] sb;
    logic [63:0] p;
    sa = {{32{a[31]}}, a};
    sb = {{32{b[31]}}, b};
    p = sgn ? sa * sb : {32'h0, a} * {32'h0, b};
    wide_mode = wide;
    // operands are given sign-extended as software must
    op(rw(5'h1, 5'h0, 5'h0, sgn ? HME_FN_SMUL : HME_FN_UMUL), sa, sb);
    chk_flag(mul_busy, 1'b1);
    idle();
    op(rw(5'h0, 5'h5, 5'h0, HME_FN_COPY_BOT), 64'h0, 64'h0);
    chk_gpr(5'h5, {wide ? {32{p[31]}} : 32'h0, p[31:0]});
    op(rw(5'h0, 5'h6, 5'h0, HME_FN_COPY_UP), 64'h0, 64'h0);
    chk_gpr(5'h6, {wide ? {32{p[63]}} : 32'h0, p[63:32]});
    idle();
  endtask
  task automatic t_undef();
    op(rw(5'h1, 5'h0, 5'h0, HME_FN_SMUL), 64'h3, 64'h5);
    idle();
    idle();
    op(rw(5'h3, 5'h0, 5'h0, HME_FN_SET_UP), 64'h1, 64'h0);
    chk_flag(prod_undef, 1'b1);
    op(rw(5'h0, 5'h7, 5'h0, HME_FN_COPY_UP), 64'h0, 64'h0);
    op(rw(5'h4, 5'h0, 5'h0, HME_FN_SET_BOT), 64'h2, 64'h0);
    chk_flag(prod_undef, 1'b0);
    idle();
  endtask
  task automatic t_sysctl();
    op(SC_WR, 64'h0, 64'hdead_beef_0123_4567);
    chk_sc(1'b0, 1'b1, 64'hdead_beef_0123_4567);
    op(SC_RD, 64'h0, 64'h0);
    chk_sc(1'b1, 1'b0, 64'h0);
    sc_rd_data = 64'h5a5a_0f0f_a5a5_f0f0;
    idle();
    chk_gpr(5'h0b, 64'h5a5a_0f0f_a5a5_f0f0);
    sc_rd_data = 64'ha5a5_f0f0_5a5a_0f0f;
    // user and supervisor, with and without the unit enabled
    for (int m = 0; m < 4; m++) begin
      priv_mode = m[1] ? HME_PM_SUPER : HME_PM_USER;
      sysctl_usable = m[0];
      op(SC_WR, 64'h0, 64'h77);
      chk_flag(exc_cop_unusable, !m[0]);
      chk_sc(1'b0, m[0], m[0] ? 64'h77 : 64'h0);
    end
    sysctl_usable = 1'b0;
    op(SC_RD, 64'h0, 64'h0);
    chk_flag(exc_cop_unusable, 1'b1);
    idle();
    chk_flag(gpr_wr.en, 1'b0);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    issue = '0;
    priv_mode = HME_PM_KERN;
    sysctl_usable = 1'b0;
    wide_mode = 1'b0;
    sc_rd_data = 64'h0;
    n_mismatch = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_set_copy();
    for (int i = 0; i < 4; i++) begin
      t_logic(64'h00ff_00ff_0f0f_f0f0, 64'h8000_0000_0000_0001 << i);
      t_signed_product_op(i[0], i[1], 32'hffff_fffd - i, 32'h8000_0007);
    end
    t_logic(64'hffff_0000_ffff_0000, 64'h0);
    t_undef();
    t_sysctl();
    close_out();
  end
  // the run needs about 63 cycles; 2000 leaves ample margin
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
endmodule
